// ### ddr_rd_pkg.sv
package ddr_rd_pkg;
  localparam int ADDR_W = 32;
  localparam int OPC_W = 4;
  localparam int DQ_W = 72;
  localparam int RQ_DEPTH = 16;
  localparam int CQ_DEPTH = 16;
  localparam logic [3:0] OPC_WRITE = 4'h0;
  localparam logic [3:0] OPC_READ = 4'h1;
  // Address layout of a request
  localparam int COL_LSB = 0;
  localparam int COL_W = 10;
  localparam int ROW_LSB = 10;
  localparam int ROW_W = 13;
  localparam int BANK_LSB = 23;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int AP_BIT = 10;
  // Cycle counts in controller clocks
  localparam int EMPTY_DLY_CLK = 5;
  localparam int EMPTY_STAGES = EMPTY_DLY_CLK - 2;
  localparam int ISSUE_DLY = 4;
  localparam int PRE_TO_ACT = 3;
  localparam int ACT_TO_RD = 4;
  localparam int REF_TRP = 3;
  localparam int BURST_BEATS = 2;
  localparam int CAP_PIPE = 32;

  typedef enum logic [3:0] {
    MC_NOP = 4'h7,
    MC_ACT = 4'h3,
    MC_RD  = 4'h5,
    MC_PRE = 4'h2,
    MC_REF = 4'h1
  } mem_op_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_WAIT = 3'h1,
    S_PRE  = 3'h2,
    S_ACT  = 3'h3,
    S_REF  = 3'h4
  } seq_e;

  typedef struct packed {
    mem_op_e op;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] addr;
  } mem_cmd_s;

  typedef struct packed {
    logic [OPC_W-1:0] opc;
    logic [ADDR_W-1:0] addr;
  } req_s;

  typedef struct packed {
    logic [DQ_W-1:0] fall;
    logic [DQ_W-1:0] rise;
  } beat_s;

  typedef struct packed {
    seq_e st;
    logic [3:0] cnt;
    req_s req;
    logic held;
    logic ref_pend;
    logic [NBANK-1:0] open;
    logic [NBANK-1:0][ROW_W-1:0] row;
    logic [EMPTY_STAGES-1:0] edly;
    logic empty;
    mem_cmd_s cmd;
    logic rd_prev;
    logic [CAP_PIPE-1:0] cap;
    logic [4:0] infl;
    logic wr_pulse;
    logic [ADDR_W-1:0] wr_addr;
    beat_s dout;
    logic dvalid;
  } top_s;

  localparam top_s TOP_RST = '{
    st: S_IDLE,
    empty: 1'b1,
    edly: '1,
    cmd: '{op: MC_NOP, default: '0},
    default: '0
  };
endpackage

// ### sync_queue.sv
`timescale 1ns/1ps
module sync_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Status
  output logic full_o,
  output logic empty_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic empty;
  } q_s;

  q_s s_ff;
  q_s nxt_s;
  logic push;
  logic pop;

  assign push = in_valid_i && !s_ff.full;
  assign pop = out_ready_i && !s_ff.empty;
  assign in_ready_o = !s_ff.full;
  assign out_valid_o = !s_ff.empty;
  assign out_data_o = s_ff.mem[s_ff.rp];
  assign full_o = s_ff.full;
  assign empty_o = s_ff.empty;
  assign count_o = s_ff.cnt;

  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wp] = in_data_i;
      nxt_s.wp = s_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_s.rp = s_ff.rp + 1'b1;
    end
    nxt_s.cnt = s_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    nxt_s.full = (nxt_s.cnt == (AW+1)'(DEPTH));
    nxt_s.empty = (nxt_s.cnt == '0);
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_ff <= '0;
      s_ff.empty <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule

// ### ddr_user_read_path.sv
`timescale 1ns/1ps
module ddr_user_read_path
  import ddr_rd_pkg::*;
#(
  parameter bit FAST_EMPTY = 1'b0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Calibration results and configuration
  input wire logic calib_done_i,
  input wire logic [4:0] rd_latency_i,
  input wire logic [2:0] cas_latency_i,
  input wire logic bank_mgmt_en_i,
  input wire logic refresh_due_i,
  // Command queue
  input wire logic cmd_queue_push_i,
  input wire logic [ADDR_W-1:0] request_address_i,
  input wire logic [OPC_W-1:0] request_opcode_i,
  output logic cmd_queue_full_o,
  output logic cmd_queue_empty_o,
  // Hand-off of write requests to the write path
  output logic write_req_o,
  output logic [ADDR_W-1:0] write_addr_o,
  // Memory command bus
  output mem_cmd_s mem_cmd_o,
  // Returned memory data, already in this clock domain
  input wire logic [DQ_W-1:0] mem_rise_i,
  input wire logic [DQ_W-1:0] mem_fall_i,
  // Read data to the user
  output beat_s rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i
);
  top_s s_ff;
  top_s nxt_s;

  logic cq_push;
  logic cq_pop;
  logic cq_valid;
  req_s cq_data;
  logic cq_empty;
  logic rq_push;
  logic rq_ready;
  logic rq_valid;
  logic rq_take;
  beat_s rq_data;
  logic [4:0] rq_count;
  logic [4:0] tap;
  logic room;

  function automatic logic [BANK_W-1:0] bank_of(logic [ADDR_W-1:0] a);
    return a[BANK_LSB +: BANK_W];
  endfunction

  function automatic logic [ROW_W-1:0] row_of(logic [ADDR_W-1:0] a);
    return a[ROW_LSB +: ROW_W];
  endfunction

  function automatic mem_cmd_s mk_cmd(mem_op_e op, logic [BANK_W-1:0] b,
                                      logic [ROW_W-1:0] a);
    mem_cmd_s c;
    c.op = op;
    c.bank = b;
    c.addr = a;
    return c;
  endfunction

  function automatic logic [ROW_W-1:0] col_addr(logic [ADDR_W-1:0] a,
                                                logic ap);
    logic [ROW_W-1:0] v;
    v = '0;
    v[COL_W-1:0] = a[COL_LSB +: COL_W];
    v[AP_BIT] = ap;
    return v;
  endfunction

  // Pushes before calibration are dropped rather than corrupting the queue
  assign cq_push = cmd_queue_push_i && calib_done_i;

  // One queue for both kinds of request
  sync_queue #(
    .WIDTH($bits(req_s)),
    .DEPTH(CQ_DEPTH)
  ) u_cmd_queue (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .in_valid_i(cq_push),
    .in_ready_o(),
    .in_data_i({request_opcode_i, request_address_i}),
    .out_valid_o(cq_valid),
    .out_ready_i(cq_pop),
    .out_data_o(cq_data),
    .full_o(cmd_queue_full_o),
    .empty_o(cq_empty),
    .count_o()
  );

  // Rise and fall halves of every bit, sixteen entries
  sync_queue #(
    .WIDTH(2 * DQ_W),
    .DEPTH(RQ_DEPTH)
  ) u_ret_queue (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .in_valid_i(rq_push),
    .in_ready_o(rq_ready),
    .in_data_i({mem_fall_i, mem_rise_i}),
    .out_valid_o(rq_valid),
    .out_ready_i(rq_take),
    .out_data_o(rq_data),
    .full_o(),
    .empty_o(),
    .count_o(rq_count)
  );

  // Capture tap: calibrated round trip plus CAS latency
  assign tap = rd_latency_i + 5'(cas_latency_i);
  assign rq_push = s_ff.cap[tap];
  assign rq_take = !s_ff.dvalid || rd_ready_i;
  // Reads stall unless both beats of every read in flight have room
  assign room = (6'(rq_count) + 6'(s_ff.infl) + 6'(BURST_BEATS)
                 <= 6'(RQ_DEPTH)) && rq_ready;
  assign cq_pop = (s_ff.st == S_IDLE) && !s_ff.ref_pend && !s_ff.empty
                  && cq_valid;

  always_comb begin
    logic hit;
    logic ref_clr;
    logic rd_now;
    logic [BANK_W-1:0] b;
    logic [ROW_W-1:0] r;
    hit = 1'b0;
    ref_clr = 1'b0;
    rd_now = 1'b0;
    b = bank_of(s_ff.req.addr);
    r = row_of(s_ff.req.addr);
    nxt_s = s_ff;
    nxt_s.cmd = mk_cmd(MC_NOP, '0, '0);
    nxt_s.wr_pulse = 1'b0;
    // Empty flag lags the queue so its fall lands five clocks after a push, two with FAST_EMPTY
    nxt_s.edly = {s_ff.edly[EMPTY_STAGES-2:0], cq_empty};
    nxt_s.empty = FAST_EMPTY ? cq_empty : s_ff.edly[EMPTY_STAGES-1];
    unique case (s_ff.st)
      S_IDLE: begin
        if (s_ff.ref_pend) begin
          nxt_s.cmd = mk_cmd(MC_PRE, '0, ROW_W'(1) << AP_BIT);
          nxt_s.st = S_REF;
          nxt_s.cnt = 4'(REF_TRP - 1);
        end else if (cq_pop) begin
          if (cq_data.opc == OPC_READ) begin
            nxt_s.req = cq_data;
            nxt_s.held = 1'b1;
            nxt_s.st = S_WAIT;
            nxt_s.cnt = 4'(ISSUE_DLY - 2);
          end else if (cq_data.opc == OPC_WRITE) begin
            nxt_s.wr_pulse = 1'b1;
            nxt_s.wr_addr = cq_data.addr;
          end
        end
      end
      S_WAIT: begin
        hit = bank_mgmt_en_i && s_ff.open[b] && (s_ff.row[b] == r);
        if (s_ff.ref_pend) begin
          // Refresh breaks in; the held read restarts afterwards
          nxt_s.cmd = mk_cmd(MC_PRE, '0, ROW_W'(1) << AP_BIT);
          nxt_s.st = S_REF;
          nxt_s.cnt = 4'(REF_TRP - 1);
        end else if (s_ff.cnt != '0) begin
          nxt_s.cnt = s_ff.cnt - 4'h1;
        end else if (hit) begin
          // Open row: straight to the read, no activate
          if (room) begin
            rd_now = 1'b1;
            nxt_s.cmd = mk_cmd(MC_RD, b, col_addr(s_ff.req.addr, 1'b0));
          end
        end else if (s_ff.open[b]) begin
          nxt_s.cmd = mk_cmd(MC_PRE, b, '0);
          nxt_s.open[b] = 1'b0;
          nxt_s.st = S_PRE;
          nxt_s.cnt = 4'(PRE_TO_ACT - 1);
        end else begin
          nxt_s.cmd = mk_cmd(MC_ACT, b, r);
          nxt_s.open[b] = bank_mgmt_en_i;
          nxt_s.row[b] = r;
          nxt_s.st = S_ACT;
          nxt_s.cnt = 4'(ACT_TO_RD - 1);
        end
      end
      S_PRE: begin
        if (s_ff.cnt != '0) begin
          nxt_s.cnt = s_ff.cnt - 4'h1;
        end else begin
          nxt_s.cmd = mk_cmd(MC_ACT, b, r);
          nxt_s.open[b] = bank_mgmt_en_i;
          nxt_s.row[b] = r;
          nxt_s.st = S_ACT;
          nxt_s.cnt = 4'(ACT_TO_RD - 1);
        end
      end
      S_ACT: begin
        if (s_ff.cnt != '0) begin
          nxt_s.cnt = s_ff.cnt - 4'h1;
        end else if (room) begin
          // Without bank management the row closes by auto precharge
          rd_now = 1'b1;
          nxt_s.cmd = mk_cmd(MC_RD, b,
                             col_addr(s_ff.req.addr, !bank_mgmt_en_i));
        end
      end
      S_REF: begin
        if (s_ff.cnt != '0) begin
          nxt_s.cnt = s_ff.cnt - 4'h1;
        end else begin
          nxt_s.cmd = mk_cmd(MC_REF, '0, '0);
          nxt_s.open = '0;
          ref_clr = 1'b1;
          nxt_s.st = s_ff.held ? S_WAIT : S_IDLE;
          nxt_s.cnt = 4'(ISSUE_DLY - 2);
        end
      end
      default: begin
        nxt_s.st = S_IDLE;
      end
    endcase
    if (rd_now) begin
      nxt_s.held = 1'b0;
      nxt_s.st = S_IDLE;
    end
    // Refresh request arriving as it is served stays pending
    nxt_s.ref_pend = (s_ff.ref_pend && !ref_clr) || refresh_due_i;
    // Command flop feeds the memory on the rising clock edge
    nxt_s.rd_prev = (s_ff.cmd.op == MC_RD);
    nxt_s.cap = {s_ff.cap[CAP_PIPE-2:0],
                 (s_ff.cmd.op == MC_RD) || s_ff.rd_prev};
    nxt_s.infl = s_ff.infl + (rd_now ? 5'(BURST_BEATS) : 5'h0)
                 - 5'(rq_push);
    // Single queue in, single queue out keeps request order
    if (rq_take) begin
      nxt_s.dvalid = rq_valid;
      nxt_s.dout = rq_data;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_ff <= TOP_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign cmd_queue_empty_o = s_ff.empty;
  assign write_req_o = s_ff.wr_pulse;
  assign write_addr_o = s_ff.wr_addr;
  assign mem_cmd_o = s_ff.cmd;
  // Output register stands in for the shifted-clock stage
  assign rd_data_o = s_ff.dout;
  assign rd_valid_o = s_ff.dvalid;
endmodule

// ### ddr_user_read_path_properties.sv
`timescale 1ns/1ps
module ddr_user_read_path_checker
  import ddr_rd_pkg::*;
#(
  parameter bit FAST_EMPTY = 1'b0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Block inputs
  input wire logic calib_done_i,
  input wire logic [4:0] rd_latency_i,
  input wire logic [2:0] cas_latency_i,
  input wire logic cmd_queue_push_i,
  input wire logic rd_ready_i,
  // Block outputs
  input wire logic cmd_queue_empty_o,
  input wire logic write_req_o,
  input wire mem_cmd_s mem_cmd_o,
  input wire beat_s rd_data_o,
  input wire logic rd_valid_o
);
  localparam int EDLY = FAST_EMPTY ? 2 : EMPTY_DLY_CLK;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence quiet2_s;
    (mem_cmd_o.op == MC_NOP) [*2];
  endsequence
  sequence quiet3_s;
    (mem_cmd_o.op == MC_NOP) [*3];
  endsequence
  sequence issue_s;
    mem_cmd_o.op inside {MC_RD, MC_ACT, MC_PRE};
  endsequence
  empty_fall_a: assert property (
    $fell(cmd_queue_empty_o) |-> $past(cmd_queue_push_i && calib_done_i, EDLY))
    else $error("empty flag fell without a push");
  // A popped write sends nothing to the memory, so it is left out
  issue_dly_a: assert property (
    $fell(cmd_queue_empty_o) ##1 !write_req_o |-> quiet3_s ##1 issue_s)
    else $error("first command not four cycles after empty fell");
  pre_act_a: assert property (
    (mem_cmd_o.op == MC_PRE && !mem_cmd_o.addr[AP_BIT])
      |=> quiet2_s ##1 (mem_cmd_o.op == MC_ACT))
    else $error("activate not three cycles after precharge");
  act_rd_a: assert property (
    (mem_cmd_o.op == MC_ACT && !rd_valid_o) |=> quiet3_s ##1
      (mem_cmd_o.op == MC_RD && mem_cmd_o.bank == $past(mem_cmd_o.bank, 4)))
    else $error("read not four cycles after activate");
  ref_close_a: assert property (
    (mem_cmd_o.op == MC_PRE && mem_cmd_o.addr[AP_BIT])
      |-> ##3 (mem_cmd_o.op == MC_REF))
    else $error("refresh not three cycles after close");
  rd_valid_a: assert property (
    ($rose(rd_valid_o) && rd_latency_i == 5'd6 && cas_latency_i == 3'd3)
      |-> $past(mem_cmd_o.op == MC_RD, 12))
    else $error("read valid not twelve cycles after read");
  valid_hold_a: assert property (
    (rd_valid_o && !rd_ready_i) |=> (rd_valid_o && $stable(rd_data_o)))
    else $error("read data dropped while not accepted");
  calib_block_a: assert property (
    (!calib_done_i && cmd_queue_empty_o) |=> cmd_queue_empty_o)
    else $error("push taken before calibration");
endmodule

bind ddr_user_read_path ddr_user_read_path_checker #(
  .FAST_EMPTY(FAST_EMPTY)
) ddr_user_read_path_checker_inst (
  .clock_i(clock_i), .nrst_i(nrst_i), .calib_done_i(calib_done_i),
  .rd_latency_i(rd_latency_i), .cas_latency_i(cas_latency_i),
  .cmd_queue_push_i(cmd_queue_push_i), .rd_ready_i(rd_ready_i),
  .cmd_queue_empty_o(cmd_queue_empty_o), .write_req_o(write_req_o),
  .mem_cmd_o(mem_cmd_o),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o)
);

// ### mem_return_model.sv
`timescale 1ns/1ps
module mem_return_model
  import ddr_rd_pkg::*;
(
  // Clock and command bus
  input wire logic clock_i,
  input wire mem_cmd_s mem_cmd_i,
  input wire logic [4:0] rd_latency_i,
  input wire logic [2:0] cas_latency_i,
  // Returned beats
  output logic [DQ_W-1:0] mem_rise_o,
  output logic [DQ_W-1:0] mem_fall_o
);
  int cyc = 0;
  beat_s due[int];
  function automatic beat_s beat_of(logic [1:0] b, logic [9:0] c, bit k);
    return '{fall: {4{4'h5, ~c, b, 1'b1, k}}, rise: {4{4'hA, c, b, 1'b0, k}}};
  endfunction
  initial {mem_fall_o, mem_rise_o} = '0;
  // Lines toggle outside a burst so a stale beat never passes for a fresh one
  always @(posedge clock_i) begin
    int t;
    t = rd_latency_i + cas_latency_i;
    if (mem_cmd_i.op == MC_RD) begin
      due[cyc + t] = beat_of(mem_cmd_i.bank, mem_cmd_i.addr[9:0], 1'b0);
      due[cyc + t + 1] = beat_of(mem_cmd_i.bank, mem_cmd_i.addr[9:0], 1'b1);
    end
    if (due.exists(cyc))
      {mem_fall_o, mem_rise_o} <= due[cyc];
    else
      {mem_fall_o, mem_rise_o} <= ~{mem_fall_o, mem_rise_o};
    cyc++;
  end
endmodule

// ### ddr_user_read_path_tb_top.sv
`timescale 1ns/1ps
module ddr_user_read_path_tb_top;
  import ddr_rd_pkg::*;
  logic clock_i, nrst_i, calib_done_i, bank_mgmt_en_i, refresh_due_i;
  logic cmd_queue_push_i, rd_ready_i, cmd_queue_full_o, cmd_queue_empty_o;
  logic write_req_o, rd_valid_o, saw_full;
  logic [4:0] rd_latency_i;
  logic [2:0] cas_latency_i;
  logic [OPC_W-1:0] request_opcode_i;
  logic [ADDR_W-1:0] request_address_i, write_addr_o;
  logic [DQ_W-1:0] mem_rise_i, mem_fall_i;
  logic [31:0] rng = 32'h8FC0;
  logic [11:0] ops;
  mem_cmd_s mem_cmd_o, last_rd;
  beat_s rd_data_o;
  beat_s exp_q[$];
  int err_count = 0, total_checks = 0, cyc = 0, rdy_pct = 100, n;
  // Closed, hit, conflict, refresh, reopen after refresh, no bank tracking
  logic [31:0] tab_a[6] = '{32'h0080_1403, 32'h0080_1408, 32'h0080_2402,
    32'h0, 32'h0080_2405, 32'h0100_0407};
  logic [11:0] tab_e[6] = '{12'h735, 12'h775, 12'h235, 12'h721, 12'h735,
    12'h735};
  logic tab_m[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

  ddr_user_read_path ddr_user_read_path_inst (
    .clock_i(clock_i), .nrst_i(nrst_i), .calib_done_i(calib_done_i),
    .rd_latency_i(rd_latency_i), .cas_latency_i(cas_latency_i),
    .bank_mgmt_en_i(bank_mgmt_en_i), .refresh_due_i(refresh_due_i),
    .cmd_queue_push_i(cmd_queue_push_i),
    .request_address_i(request_address_i),
    .request_opcode_i(request_opcode_i),
    .cmd_queue_full_o(cmd_queue_full_o),
    .cmd_queue_empty_o(cmd_queue_empty_o), .write_req_o(write_req_o),
    .write_addr_o(write_addr_o), .mem_cmd_o(mem_cmd_o),
    .mem_rise_i(mem_rise_i), .mem_fall_i(mem_fall_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i)
  );
  mem_return_model mem_return_model_inst (
    .clock_i(clock_i), .mem_cmd_i(mem_cmd_o), .rd_latency_i(rd_latency_i),
    .cas_latency_i(cas_latency_i), .mem_rise_o(mem_rise_i),
    .mem_fall_o(mem_fall_i)
  );

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (!ok) begin
      err_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Entered at a falling edge; caller lowers the strobe after the last one
  task automatic push(input logic [31:0] a, input logic [3:0] opc);
    if (calib_done_i && !cmd_queue_full_o && opc == OPC_READ) begin
      exp_q.push_back(mem_return_model_inst.beat_of(a[24:23], a[9:0], 0));
      exp_q.push_back(mem_return_model_inst.beat_of(a[24:23], a[9:0], 1));
    end
    cmd_queue_push_i = 1'b1;
    request_address_i = a;
    request_opcode_i = opc;
    @(negedge clock_i);
  endtask
  task automatic drain();
    int k;
    k = 0;
    while ((exp_q.size() != 0 || !cmd_queue_empty_o) && k < 3000) begin
      @(negedge clock_i);
      k++;
    end
    repeat (16) @(negedge clock_i);
    check(exp_q.size() == 0, "read data missing");
  endtask

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      check(1'b0, "timeout");
      wrap_up();
    end
  end
  always @(negedge clock_i) begin
    rng = xs(rng);
    rd_ready_i <= (rng % 100) < rdy_pct;
  end
  always @(posedge clock_i) begin
    if (nrst_i && mem_cmd_o.op !== MC_NOP) begin
      ops = {ops[7:0], mem_cmd_o.op};
      if (mem_cmd_o.op === MC_RD)
        last_rd = mem_cmd_o;
    end
    if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
      if (exp_q.size() == 0)
        check(1'b0, "unexpected read data");
      else
        check(rd_data_o === exp_q.pop_front(), "read data");
    end
  end

  initial begin
    {nrst_i, calib_done_i, cmd_queue_push_i, refresh_due_i} = 4'h0;
    bank_mgmt_en_i = 1'b1;
    rd_latency_i = 5'd6;
    cas_latency_i = 3'd3;
    request_address_i = '0;
    request_opcode_i = '0;
    ops = 12'h777;
    repeat (5) @(negedge clock_i);
    nrst_i = 1'b1;
    check(cmd_queue_empty_o === 1'b1, "reset empty");
    check(rd_valid_o === 1'b0, "reset valid");
    push(32'h0080_1403, OPC_READ);
    cmd_queue_push_i = 1'b0;
    repeat (12) @(negedge clock_i);
    check(cmd_queue_empty_o === 1'b1 && ops === 12'h777, "early push");
    $display("test calibration gate done");
    calib_done_i = 1'b1;
    foreach (tab_a[i]) begin
      bank_mgmt_en_i = tab_m[i];
      ops = 12'h777;
      if (tab_a[i] == '0) begin
        refresh_due_i = 1'b1;
        @(negedge clock_i);
        refresh_due_i = 1'b0;
      end else begin
        push(tab_a[i], OPC_READ);
        cmd_queue_push_i = 1'b0;
      end
      drain();
      check(ops === tab_e[i], "command order");
      if (tab_a[i] != '0)
        check(last_rd.bank === tab_a[i][24:23] && last_rd.addr[9:0] === tab_a[i][9:0], "read address");
      $display("test directed %0d done", i);
    end
    ops = 12'h777;
    push(32'h0123_4567, OPC_WRITE);
    push(32'h0080_1403, 4'h9);
    cmd_queue_push_i = 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge clock_i);
      #1;
      if (write_req_o === 1'b1) begin
        n++;
        check(write_addr_o === 32'h0123_4567, "write address");
      end
    end
    check(n == 1 && ops === 12'h777, "opcode decode");
    $display("test opcodes done");
    @(negedge clock_i);
    for (int p = 0; p < 2; p++) begin
      rd_latency_i = p ? 5'd2 : 5'd6;
      cas_latency_i = p ? 3'd2 : 3'd3;
      rdy_pct = 60;
      saw_full = 1'b0;
      n = 0;
      while (n < 24) begin
        rng = xs(rng);
        if (cmd_queue_full_o)
          saw_full = 1'b1;
        else
          n++;
        push(rng, OPC_READ);
      end
      cmd_queue_push_i = 1'b0;
      drain();
      check(saw_full === 1'b1, "queue never full");
      rdy_pct = 100;
      $display("test burst %0d done", p);
    end
    wrap_up();
  end
endmodule
